// file: kpi_pkg.sv
// kpi_pkg: register map, field positions and reset values of the key interrupt block
// assumes a 32-bit avalon-mm slave port with byte addresses
package kpi_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int PIN_N = 4;
  localparam int REG_W = 8;
  localparam int IRQ_W = 2;

  localparam logic [4:0] OFF_STATUS_CONTROL = 5'h00;
  localparam logic [4:0] OFF_PIN_ENABLE = 5'h04;
  localparam logic [4:0] OFF_POLARITY_SELECT = 5'h08;
  localparam logic [4:0] OFF_IRQ_STATUS = 5'h0C;
  localparam logic [4:0] OFF_IRQ_MASK = 5'h10;

  localparam int BIT_DETECT_MODE = 0;
  localparam int BIT_REQUEST_ENABLE = 1;
  localparam int BIT_ACKNOWLEDGE = 2;
  localparam int BIT_EVENT_FLAG = 3;

  localparam int EV_FLAG_SET = 0;
  localparam int EV_ACK_REFUSED = 1;

  localparam logic RST_EVENT_FLAG = 1'b0;
  localparam logic RST_REQUEST_ENABLE = 1'b0;
  localparam logic RST_DETECT_MODE = 1'b0;
  localparam logic [3:0] RST_PIN_ENABLE = 4'h0;
  localparam logic [3:0] RST_POLARITY = 4'h0;
  localparam logic [1:0] RST_IRQ_STATUS = 2'h0;
  localparam logic [1:0] RST_IRQ_MASK = 2'h0;
  localparam logic RST_WAITREQUEST = 1'b1;
  localparam logic [31:0] RST_READDATA = 32'h0000_0000;
endpackage

// file: kpi_avalon_slave.sv
// kpi_avalon_slave: avalon-mm handshake, one wait state on every access
// assumes the master holds its request until it samples waitrequest low
module kpi_avalon_slave (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] rdData,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic wrAccept
);
  typedef struct packed {
    logic waitReq;
    logic [31:0] readData;
  } kpi_slave_state_t;

  kpi_slave_state_t st_r;
  kpi_slave_state_t st_nxt;

  // access completes at the edge where waitrequest is seen low
  assign wrAccept = avs_write && !st_r.waitReq;
  assign avs_readdata = st_r.readData;
  assign avs_waitrequest = st_r.waitReq;

  always_comb begin
    st_nxt = st_r;
    if (st_r.waitReq && (avs_read || avs_write)) begin
      st_nxt.waitReq = 1'b0;
      st_nxt.readData = avs_read ? rdData : kpi_pkg::RST_READDATA;
    end else if (!st_r.waitReq) begin
      st_nxt.waitReq = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r.waitReq <= kpi_pkg::RST_WAITREQUEST;
      st_r.readData <= kpi_pkg::RST_READDATA;
    end else begin
      st_r <= st_nxt;
    end
  end

  AST_ONE_WAIT_STATE: assert property (@(posedge clk) disable iff (sys_rst)
    (avs_waitrequest && (avs_read || avs_write)) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("slave did not answer after exactly one wait state");
endmodule

// file: kpi_pin_detect.sv
// kpi_pin_detect: per-pin assertion, edge and level detection for the key inputs
// assumes pins are already synchronous to clk
module kpi_pin_detect (
  input wire logic clk,
  input wire logic blockRst,
  input wire logic [3:0] keyInputPin,
  input wire logic [3:0] pinSourceEnable,
  input wire logic [3:0] pinPolarityBit,
  output logic edgeHit,
  output logic levelHit
);
  typedef struct packed {
    logic [3:0] prevAsserted;
    logic armed;
  } kpi_detect_state_t;

  kpi_detect_state_t st_r;
  kpi_detect_state_t st_nxt;
  logic [3:0] asserted;
  logic [3:0] pinEdge;

  genvar i;
  generate
    for (i = 0; i < kpi_pkg::PIN_N; i++) begin : g_pin
      // polarity 0 means low asserted, 1 means high asserted
      assign asserted[i] = ~(keyInputPin[i] ^ pinPolarityBit[i]);
      assign pinEdge[i] = pinSourceEnable[i] && !st_r.prevAsserted[i] && asserted[i];
    end
  endgenerate

  // no new edge until every enabled input has gone back to deasserted
  assign edgeHit = st_r.armed && |pinEdge;
  assign levelHit = |(pinSourceEnable & asserted);

  always_comb begin
    st_nxt = st_r;
    st_nxt.prevAsserted = asserted;
    if (edgeHit) begin
      st_nxt.armed = 1'b0;
    end else if (!levelHit) begin
      st_nxt.armed = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (blockRst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  AST_NO_BACK_TO_BACK_EDGE: assert property (@(posedge clk) disable iff (blockRst)
    edgeHit |=> !edgeHit)
    else $error("second edge seen without return to deasserted");
endmodule

// file: kpi_keyboard_irq.sv
// kpi_keyboard_irq: keyboard-style pin interrupt block with avalon-mm registers
// assumes key pins synchronous to clk and power-mode levels from the system controller
//
// Register access over Avalon-MM and the register addresses were chosen for this implementation.
module kpi_keyboard_irq (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [3:0] keyInputPin,
  input wire logic waitMode,
  input wire logic stop3Mode,
  input wire logic deepStop,
  output logic keyIrqRequest,
  output logic wakeRequest,
  output logic irqOut
);
  typedef struct packed {
    logic eventFlag;
    logic requestEnable;
    logic detectMode;
    logic [3:0] pinSourceEnable;
    logic [3:0] pinPolarityBit;
    logic [1:0] irqStatus;
    logic [1:0] irqMask;
    logic keyIrq;
    logic wake;
    logic irq;
  } kpi_top_state_t;

  kpi_top_state_t st_r;
  kpi_top_state_t st_nxt;
  logic blockRst;
  logic wrAccept;
  logic edgeHit;
  logic levelHit;
  logic [31:0] rdData;
  logic ctrlWrite;
  logic ackWrite;
  logic levelHold;
  logic setFlag;
  logic [1:0] irqEvent;
  logic [1:0] irqClear;

  // deep stop loses all state but the bus slave's, same as a reset
  assign blockRst = sys_rst || deepStop;

  kpi_avalon_slave u_slave (
    .clk(clk),
    .sys_rst(sys_rst),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .rdData(rdData),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .wrAccept(wrAccept)
  );

  // detection ignores debug halt and runs in wait and stop3 alike
  kpi_pin_detect u_detect (
    .clk(clk),
    .blockRst(blockRst),
    .keyInputPin(keyInputPin),
    .pinSourceEnable(st_r.pinSourceEnable),
    .pinPolarityBit(st_r.pinPolarityBit),
    .edgeHit(edgeHit),
    .levelHit(levelHit)
  );

  always_comb begin
    rdData = 32'h0000_0000;
    if (avs_address == kpi_pkg::OFF_STATUS_CONTROL) begin
      // upper nibble and acknowledge always read zero
      rdData[kpi_pkg::BIT_EVENT_FLAG] = st_r.eventFlag;
      rdData[kpi_pkg::BIT_REQUEST_ENABLE] = st_r.requestEnable;
      rdData[kpi_pkg::BIT_DETECT_MODE] = st_r.detectMode;
    end else if (avs_address == kpi_pkg::OFF_PIN_ENABLE) begin
      // unimplemented pins 7:4 read zero
      rdData[3:0] = st_r.pinSourceEnable;
    end else if (avs_address == kpi_pkg::OFF_POLARITY_SELECT) begin
      rdData[3:0] = st_r.pinPolarityBit;
    end else if (avs_address == kpi_pkg::OFF_IRQ_STATUS) begin
      rdData[1:0] = st_r.irqStatus;
    end else if (avs_address == kpi_pkg::OFF_IRQ_MASK) begin
      rdData[1:0] = st_r.irqMask;
    end else begin
      rdData = 32'h0000_0000;
    end
  end

  assign ctrlWrite = wrAccept && avs_byteenable[0] && (avs_address == kpi_pkg::OFF_STATUS_CONTROL);
  assign ackWrite = ctrlWrite && avs_writedata[kpi_pkg::BIT_ACKNOWLEDGE];
  // an asserted level only counts in edge-and-level mode
  assign levelHold = st_r.detectMode && levelHit;
  assign setFlag = edgeHit || levelHold;
  assign irqEvent[kpi_pkg::EV_FLAG_SET] = setFlag && !st_r.eventFlag;
  assign irqEvent[kpi_pkg::EV_ACK_REFUSED] = ackWrite && levelHold;
  assign irqClear = (wrAccept && avs_byteenable[0] && (avs_address == kpi_pkg::OFF_IRQ_STATUS)) ?
    avs_writedata[1:0] : 2'h0;

  always_comb begin
    st_nxt = st_r;
    if (ctrlWrite) begin
      st_nxt.requestEnable = avs_writedata[kpi_pkg::BIT_REQUEST_ENABLE];
      st_nxt.detectMode = avs_writedata[kpi_pkg::BIT_DETECT_MODE];
    end
    if (wrAccept && avs_byteenable[0]) begin
      if (avs_address == kpi_pkg::OFF_PIN_ENABLE) begin
        st_nxt.pinSourceEnable = avs_writedata[3:0];
      end else if (avs_address == kpi_pkg::OFF_POLARITY_SELECT) begin
        st_nxt.pinPolarityBit = avs_writedata[3:0];
      end else if (avs_address == kpi_pkg::OFF_IRQ_MASK) begin
        st_nxt.irqMask = avs_writedata[1:0];
      end
    end
    // set beats clear, so a held level survives the acknowledge
    if (setFlag) begin
      st_nxt.eventFlag = 1'b1;
    end else if (ackWrite) begin
      st_nxt.eventFlag = 1'b0;
    end
    st_nxt.irqStatus = (st_r.irqStatus & ~irqClear) | irqEvent;
    st_nxt.keyIrq = st_nxt.eventFlag && st_nxt.requestEnable;
    // stop3 runs on this clock too; the pin path needs no bus cycle to register
    st_nxt.wake = st_nxt.keyIrq && (waitMode || stop3Mode);
    st_nxt.irq = |(st_nxt.irqStatus & st_nxt.irqMask);
  end

  always_ff @(posedge clk) begin
    if (blockRst) begin
      st_r.eventFlag <= kpi_pkg::RST_EVENT_FLAG;
      st_r.requestEnable <= kpi_pkg::RST_REQUEST_ENABLE;
      st_r.detectMode <= kpi_pkg::RST_DETECT_MODE;
      st_r.pinSourceEnable <= kpi_pkg::RST_PIN_ENABLE;
      st_r.pinPolarityBit <= kpi_pkg::RST_POLARITY;
      st_r.irqStatus <= kpi_pkg::RST_IRQ_STATUS;
      st_r.irqMask <= kpi_pkg::RST_IRQ_MASK;
      st_r.keyIrq <= 1'b0;
      st_r.wake <= 1'b0;
      st_r.irq <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign keyIrqRequest = st_r.keyIrq;
  assign wakeRequest = st_r.wake;
  assign irqOut = st_r.irq;

  AST_CTRL_UPPER_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
    (avs_read && !avs_waitrequest && $past(avs_address) == kpi_pkg::OFF_STATUS_CONTROL
      && avs_address == kpi_pkg::OFF_STATUS_CONTROL) |-> avs_readdata[7:4] == 4'h0)
    else $error("status control upper bits not zero");

  AST_ACK_READS_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
    (avs_read && !avs_waitrequest && avs_address == kpi_pkg::OFF_STATUS_CONTROL)
      |-> !avs_readdata[kpi_pkg::BIT_ACKNOWLEDGE])
    else $error("acknowledge bit read as one");

  AST_PINS_UPPER_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
    (avs_read && !avs_waitrequest && avs_address == kpi_pkg::OFF_PIN_ENABLE)
      |-> avs_readdata[7:4] == 4'h0)
    else $error("unimplemented pin enables not zero");

  AST_WRITE_NO_FLAG: assert property (@(posedge clk) disable iff (blockRst)
    (ctrlWrite && !avs_writedata[kpi_pkg::BIT_ACKNOWLEDGE] && !setFlag)
      |=> st_r.eventFlag == $past(st_r.eventFlag))
    else $error("register write changed the flag");

  AST_EDGE_SETS_FLAG: assert property (@(posedge clk) disable iff (blockRst)
    edgeHit |=> st_r.eventFlag ##1 (st_r.eventFlag || $past(ackWrite)))
    else $error("edge did not set the flag");

  AST_LEVEL_BLOCKS_ACK: assert property (@(posedge clk) disable iff (blockRst)
    (ackWrite && st_r.detectMode && levelHit) |=> st_r.eventFlag && st_r.irqStatus[kpi_pkg::EV_ACK_REFUSED])
    else $error("flag cleared while level still asserted");

  AST_EDGE_MODE_ACK_CLEARS: assert property (@(posedge clk) disable iff (blockRst)
    (ackWrite && !st_r.detectMode && !edgeHit) |=> !st_r.eventFlag ##1 !keyIrqRequest || st_r.eventFlag)
    else $error("acknowledge in edge mode did not clear");

  AST_DISABLED_PINS_SILENT: assert property (@(posedge clk) disable iff (blockRst)
    (st_r.pinSourceEnable == 4'h0) |-> !edgeHit && !levelHit)
    else $error("disabled pins produced an event");

  AST_REQUEST_GATED: assert property (@(posedge clk) disable iff (blockRst)
    keyIrqRequest |-> st_r.eventFlag && st_r.requestEnable)
    else $error("interrupt request without enable and flag");

  AST_WAKE_NEEDS_MODE: assert property (@(posedge clk) disable iff (blockRst)
    wakeRequest |-> keyIrqRequest && $past(waitMode || stop3Mode))
    else $error("wake without low power mode or request");

  AST_DEEP_STOP_RESETS: assert property (@(posedge clk) disable iff (sys_rst)
    deepStop |=> !st_r.eventFlag && st_r.pinSourceEnable == 4'h0 && !keyIrqRequest && !irqOut)
    else $error("deep stop left block state");
endmodule

// file: kpi_key_switch_model.sv
// kpi_key_switch_model: key switches with pull resistors on the four key pins
// assumes the pull direction follows the polarity the block was given
module kpi_key_switch_model (
  input wire logic clk,
  input wire logic [3:0] pressed,
  input wire logic [3:0] pullDown,
  output logic [3:0] keyInputPin
);
  // released pin sits at its pull level, a pressed pin at the opposite one
  // driven at the clock edge: the block expects pins synchronous to clk
  always_ff @(posedge clk) begin
    keyInputPin <= ~(pressed ^ pullDown);
  end
endmodule

// file: tb_top.sv
// tb_top: register-level tests of the key interrupt block
// assumes the one-wait-state avalon slave and the switch model beside it
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [4:0] SC = kpi_pkg::OFF_STATUS_CONTROL;
  localparam logic [4:0] PE = kpi_pkg::OFF_PIN_ENABLE;
  localparam logic [4:0] PS = kpi_pkg::OFF_POLARITY_SELECT;
  localparam logic [4:0] IS = kpi_pkg::OFF_IRQ_STATUS;
  localparam logic [4:0] IM = kpi_pkg::OFF_IRQ_MASK;
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  logic [4:0] addr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'hF;
  logic [31:0] rdata;
  logic waitReq;
  logic [3:0] pins;
  logic [3:0] pressed = 4'h0;
  logic [3:0] pullDown = 4'h0;
  logic waitMode = 1'b0;
  logic stop3Mode = 1'b0;
  logic deepStop = 1'b0;
  logic keyIrq;
  logic wake;
  logic irqOut;
  logic [31:0] d;
  int err_count = 0;
  int samples_checked = 0;

  always #50 clk = ~clk;

  kpi_key_switch_model sw (.clk(clk), .pressed(pressed), .pullDown(pullDown), .keyInputPin(pins));

  kpi_keyboard_irq dut (.clk(clk), .sys_rst(sysRst), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(waitReq),
    .keyInputPin(pins), .waitMode(waitMode), .stop3Mode(stop3Mode), .deepStop(deepStop),
    .keyIrqRequest(keyIrq), .wakeRequest(wake), .irqOut(irqOut));

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // request held until waitrequest is sampled low; one idle edge after it
  task busDo(input logic isWr, input logic [4:0] a, input logic [31:0] w, output logic [31:0] r);
    int n;
    n = 0;
    addr <= a;
    wdata <= w;
    rd <= !isWr;
    wr <= isWr;
    @(posedge clk);
    while (waitReq !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20) err_count++;
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task wrReg(input logic [4:0] a, input logic [31:0] w);
    busDo(1'b1, a, w, d);
  endtask

  task rdChk(input string name, input logic [4:0] a, input logic [31:0] exp);
    busDo(1'b0, a, 32'h0, d);
    check(name, d, exp);
  endtask

  task settle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task results;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    sysRst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 5; i++) rdChk("resetValue", 5'(i * 4), 32'h0);
    wrReg(SC, 32'hFF);
    rdChk("scBits", SC, 32'h3);
    wrReg(SC, 32'h0);
    wrReg(5'h14, 32'hFF);
    rdChk("unmapped", 5'h14, 32'h0);
    be <= 4'hE;
    wrReg(PE, 32'hF);
    be <= 4'hF;
    rdChk("byteEnableOff", PE, 32'h0);
    wrReg(IM, 32'h1);
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 4; i++) begin
        pullDown <= {4{p[0]}};
        wrReg(PS, p[0] ? 32'hF : 32'h0);
        wrReg(PE, 32'h1 << i);
        wrReg(SC, 32'h6);
        wrReg(IS, 32'h3);
        rdChk("noEvent", SC, 32'h2);
        pressed <= 4'h1 << ((i + 1) % 4);
        settle(3);
        rdChk("disabledPin", SC, 32'h2);
        pressed <= 4'h1 << i;
        settle(3);
        rdChk("edgeFlag", SC, 32'hA);
        check("irqRequest", {31'h0, keyIrq}, 32'h1);
        check("irqOut", {31'h0, irqOut}, 32'h1);
        wrReg(SC, 32'h6);
        rdChk("ackWhileHeld", SC, 32'h2);
        pressed <= 4'h0;
        settle(3);
        pressed <= 4'h1 << i;
        settle(3);
        rdChk("rearmed", SC, 32'hA);
        pressed <= 4'h0;
        settle(2);
      end
    end
    // level mode: acknowledge is refused while pin three stays asserted
    // clear the flag left by the edge loop so the level press raises a fresh set event
    wrReg(SC, 32'h7);
    wrReg(IS, 32'h3);
    pressed <= 4'h8;
    settle(3);
    wrReg(SC, 32'h7);
    rdChk("levelHold", SC, 32'hB);
    rdChk("ackRefused", IS, 32'h3);
    pressed <= 4'h0;
    settle(3);
    wrReg(SC, 32'h7);
    rdChk("levelClear", SC, 32'h3);
    wrReg(SC, 32'h1);
    pressed <= 4'h8;
    settle(3);
    rdChk("levelFlag", SC, 32'h9);
    check("requestOff", {31'h0, keyIrq}, 32'h0);
    wrReg(SC, 32'h3);
    for (int m = 0; m < 3; m++) begin
      waitMode <= (m == 1);
      stop3Mode <= (m == 2);
      settle(3);
      check("wake", {31'h0, wake}, (m != 0) ? 32'h1 : 32'h0);
    end
    wrReg(IM, 32'h0);
    settle(2);
    check("irqMasked", {31'h0, irqOut}, 32'h0);
    waitMode <= 1'b0;
    stop3Mode <= 1'b0;
    deepStop <= 1'b1;
    settle(2);
    deepStop <= 1'b0;
    @(posedge clk);
    rdChk("deepStopSc", SC, 32'h0);
    rdChk("deepStopPe", PE, 32'h0);
    check("deepStopReq", {31'h0, keyIrq}, 32'h0);
    results();
  end

  // the tests take under five hundred cycles; a hang ends far beyond that
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    results();
  end
endmodule
